// ==== bench/pseudo_static_ram_access_refresh_tb.sv ====
// testbench for the pseudo static ram controller
`timescale 1ns/1ns
module pseudo_static_ram_access_refresh_tb;
  localparam int INIT = 20;
  logic             core_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             req_valid = 1'b0;
  psr_pkg::psr_op_t req_op = psr_pkg::OP_NONE;
  logic [18:0]      req_addr = 19'h00000;
  logic [7:0]       req_wdata = 8'h00;
  logic             sleep_req = 1'b0;
  logic             req_ready, rsp_valid, sleep_active, init_done;
  logic             chip_select_n, output_enable_refresh_n, read_write;
  logic             data_lines_oe_n, dev_oe;
  logic [18:0]      addr_lines;
  logic [7:0]       rsp_rdata, data_lines_o, dev_q, q;
  logic [7:0]       last_v = 8'h00;
  logic [7:0]       bus_v;
  logic [15:0]      viol, autos, selfs, a0;
  int               errors = 0;
  int               cmp_count = 0;
  int               cyc = 0;
  // undriven bus shows a pattern that flips every cycle
  assign bus_v = !data_lines_oe_n ? data_lines_o : dev_oe ? dev_q : ~last_v;
  always @(posedge core_clk) last_v <= bus_v;
  psr_ctrl #(.INIT_CYC(INIT)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .sleep_req(sleep_req), .sleep_active(sleep_active),
    .init_done(init_done), .chip_select_n(chip_select_n),
    .output_enable_refresh_n(output_enable_refresh_n), .read_write(read_write),
    .addr_lines(addr_lines), .data_lines_o(data_lines_o),
    .data_lines_oe_n(data_lines_oe_n), .data_lines_i(bus_v));
  psr_dev_model #(.INIT_NS(INIT * 8)) i_dev (
    .chip_select_n(chip_select_n), .output_enable_refresh_n(output_enable_refresh_n),
    .read_write(read_write), .addr_lines(addr_lines), .data_in(bus_v),
    .data_out(dev_q), .data_oe(dev_oe), .viol_count(viol), .auto_count(autos),
    .self_count(selfs));
  initial forever #4 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, run needs about 6000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      complete_run();
    end
  end
  // both parties must never drive the data lines together
  always @(negedge core_clk) if (rst_n && !data_lines_oe_n && dev_oe) chk(32'h1, 32'h0);
  task automatic xfer(input psr_pkg::psr_op_t op, input logic [18:0] a,
                      input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(negedge core_clk);
    {req_valid, req_op, req_addr, req_wdata} = {1'b1, op, a, d};
    while (req_ready !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 3200) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 3000) chk(32'(n), 32'h0);
    r = rsp_rdata;
  endtask
  task automatic t_init();
    int n;
    n = 0;
    chk(32'(init_done), 32'h0);
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    chk(32'(n >= INIT - 1 && n < INIT + 3), 32'h1);
    chk(32'(init_done), 32'h1);
  endtask
  task automatic t_wr_rd();
    xfer(psr_pkg::OP_WRITE, 19'h7ffff, 8'ha5, q);
    xfer(psr_pkg::OP_WRITE, 19'h00000, 8'h5a, q);
    chk(32'(i_dev.mem[19'h7ffff]), 32'ha5);
    xfer(psr_pkg::OP_READ, 19'h7ffff, 8'h00, q);
    chk(32'(q), 32'ha5);
    xfer(psr_pkg::OP_READ, 19'h00000, 8'h00, q);
    chk(32'(q), 32'h5a);
  endtask
  task automatic t_b2b_rmw();
    xfer(psr_pkg::OP_WRITE, 19'h12345, 8'hc3, q);
    xfer(psr_pkg::OP_RMW, 19'h12345, 8'h96, q);
    chk(32'(q), 32'hc3);
    chk(32'(i_dev.mem[19'h12345]), 32'h96);
    xfer(psr_pkg::OP_READ, 19'h12345, 8'h00, q);
    chk(32'(q), 32'h96);
  endtask
  task automatic t_auto();
    a0 = autos;
    repeat (4000) @(negedge core_clk);
    // interval of 1953 cycles gives two pulses, three if one was pending
    chk(32'(autos - a0 inside {16'h2, 16'h3}), 32'h1);
  endtask
  task automatic t_self();
    int n;
    n = 0;
    a0 = selfs;
    sleep_req = 1'b1;
    repeat (1500) @(negedge core_clk);
    chk(32'({sleep_active, chip_select_n, output_enable_refresh_n}), 32'h6);
    sleep_req = 1'b0;
    while (sleep_active !== 1'b0 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    chk(32'(selfs - a0), 32'h1);
    xfer(psr_pkg::OP_READ, 19'h7ffff, 8'h00, q);
    chk(32'(q), 32'ha5);
  endtask
  initial begin
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    t_init();
    t_wr_rd();
    t_b2b_rmw();
    t_auto();
    t_self();
    chk(32'(viol), 32'h0);
    complete_run();
  end
endmodule // pseudo_static_ram_access_refresh_tb

// ==== bench/psr_dev_model.sv ====
// behavioural pseudo static ram standing on the pin side of the controller
`timescale 1ns/1ns
module psr_dev_model #(
  parameter int INIT_NS = 100000,
  parameter int ACC_NS  = 150
) (
  input  wire logic        chip_select_n,
  input  wire logic        output_enable_refresh_n,
  input  wire logic        read_write,
  input  wire logic [18:0] addr_lines,
  input  wire logic [7:0]  data_in,
  output logic [7:0]       data_out,
  output logic             data_oe,
  output logic [15:0]      viol_count,
  output logic [15:0]      auto_count,
  output logic [15:0]      self_count
);
  logic [7:0]  mem [0:524287];
  logic [18:0] lat_addr;
  logic [10:0] row_cnt = 11'h000;
  logic        acc_ok = 1'b0;
  logic        stored, rd_seen, prev_rmw, rf_low, last_self;
  time         t_cs_fall, t_cs_rise, t_rf_fall, t_rf_rise, t_dchg, w;
  initial begin
    {viol_count, auto_count, self_count} = '0;
    {stored, rd_seen, prev_rmw, rf_low, last_self} = '0;
    {t_cs_fall, t_cs_rise, t_rf_fall, t_rf_rise, t_dchg} = '0;
  end
  assign data_oe = !chip_select_n && !output_enable_refresh_n && read_write;
  // bus shows junk until access time has run out
  always @(*) data_out = acc_ok ? mem[lat_addr] : ~lat_addr[7:0];
  always @(posedge acc_ok) if (data_oe) rd_seen = 1'b1;
  always @(data_in) t_dchg = $time;
  task automatic store();
    if ($time - t_dchg < 30) viol_count++;
    mem[lat_addr] = data_in;
    stored = 1'b1;
  endtask
  always @(negedge chip_select_n) begin
    if ($time < INIT_NS) viol_count++;
    if (t_cs_fall != 0 && $time - t_cs_fall < (prev_rmw ? 290 : 230)) viol_count++;
    if (last_self && $time - t_rf_rise < 300) viol_count++;
    lat_addr = addr_lines;
    {stored, rd_seen, last_self} = '0;
    t_cs_fall = $time;
    #ACC_NS acc_ok = !chip_select_n;
  end
  always @(posedge read_write) if (!chip_select_n && !stored) begin
    if ($time - t_cs_fall < 70) viol_count++;
    store();
  end
  // earlier edge stores; a select-only cycle keeps data
  always @(posedge chip_select_n) begin
    if (read_write === 1'b0 && !stored) store();
    acc_ok = 1'b0;
    t_cs_rise = $time;
    prev_rmw = rd_seen && stored;
  end
  // select and refresh pins move on one edge: let both settle before judging
  always @(negedge output_enable_refresh_n) begin
    #1;
    if (chip_select_n === 1'b1) begin
      if ($time - 1 - t_cs_rise < 80) viol_count++;
      if (auto_count != 0 && $time - 1 - t_rf_fall < 230) viol_count++;
      t_rf_fall = $time - 1;
      rf_low = 1'b1;
    end
  end
  // kind chosen by pulse width, rows counted inside
  always @(posedge output_enable_refresh_n) if (chip_select_n === 1'b1 && rf_low) begin
    w = $time - t_rf_fall;
    if (w >= 8000) begin
      self_count++;
      last_self = 1'b1;
    end else if (w >= 80) begin
      auto_count++;
      row_cnt++;
    end else viol_count++;
    rf_low = 1'b0;
    t_rf_rise = $time;
  end
  always begin
    #15625;
    if (rf_low && $time - t_rf_fall >= 8000) row_cnt++;
  end
endmodule // psr_dev_model

// ==== src/psr_ctrl.sv ====
// host-side access and refresh controller for a byte-wide pseudo static ram
`timescale 1ns/1ns
`include "psr_regs.svh"
module psr_ctrl #(
  parameter int INIT_CYC = `PSR_INIT_CYC
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             req_valid,
  output logic                  req_ready,
  input  wire psr_pkg::psr_op_t req_op,
  input  wire logic [18:0]      req_addr,
  input  wire logic [7:0]       req_wdata,
  output logic                  rsp_valid,
  output logic [7:0]            rsp_rdata,
  input  wire logic             sleep_req,
  output logic                  sleep_active,
  output logic                  init_done,
  output logic                  chip_select_n,
  output logic                  output_enable_refresh_n,
  output logic                  read_write,
  output logic [18:0]           addr_lines,
  output logic [7:0]            data_lines_o,
  output logic                  data_lines_oe_n,
  input  wire logic [7:0]       data_lines_i
);
  localparam int CNT_W = 14;

  function automatic logic at_cnt(input logic [CNT_W-1:0] c, input int n);
    return c == CNT_W'(n - 1);
  endfunction

  // package states under short local names
  localparam psr_pkg::psr_state_t ST_INIT      = psr_pkg::ST_INIT;
  localparam psr_pkg::psr_state_t ST_IDLE      = psr_pkg::ST_IDLE;
  localparam psr_pkg::psr_state_t ST_RD        = psr_pkg::ST_RD;
  localparam psr_pkg::psr_state_t ST_WR        = psr_pkg::ST_WR;
  localparam psr_pkg::psr_state_t ST_RMW       = psr_pkg::ST_RMW;
  localparam psr_pkg::psr_state_t ST_PRE       = psr_pkg::ST_PRE;
  localparam psr_pkg::psr_state_t ST_REF_LO    = psr_pkg::ST_REF_LO;
  localparam psr_pkg::psr_state_t ST_REF_HI    = psr_pkg::ST_REF_HI;
  localparam psr_pkg::psr_state_t ST_SELF      = psr_pkg::ST_SELF;
  localparam psr_pkg::psr_state_t ST_SELF_EXIT = psr_pkg::ST_SELF_EXIT;

  psr_pkg::psr_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [10:0]      tmr_reg, tmr_next;
  logic             pend_reg, pend_next;
  logic             ce_n_reg, ce_n_next;
  logic             oe_n_reg, oe_n_next;
  logic             rw_reg, rw_next;
  logic [18:0]      addr_reg, addr_next;
  logic [7:0]       dout_reg, dout_next;
  logic             doe_n_reg, doe_n_next;
  logic [7:0]       rdata_reg, rdata_next;
  logic             rsp_reg, rsp_next;
  logic [7:0]       sync1_reg, sync2_reg;
  logic             tmr_hit;
  logic             pend_clr;

  // pins are async to us: two flops before use
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= data_lines_i;
      sync2_reg <= sync1_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + CNT_W'(1);
    ce_n_next  = ce_n_reg;
    oe_n_next  = oe_n_reg;
    rw_next    = rw_reg;
    addr_next  = addr_reg;
    dout_next  = dout_reg;
    doe_n_next = doe_n_reg;
    rdata_next = rdata_reg;
    rsp_next   = 1'b0;
    pend_clr   = 1'b0;
    case (state_reg)
      ST_INIT: begin
        // RULE_16: initial pause
        if (at_cnt(cnt_reg, INIT_CYC)) begin
          state_next = ST_IDLE;
          cnt_next   = '0;
        end
      end
      ST_IDLE: begin
        cnt_next = '0;
        // RULE_13: refresh wins over access
        if (pend_reg) begin
          state_next = ST_REF_LO;
          oe_n_next  = 1'b0;
          pend_clr   = 1'b1;
        end else if (sleep_req) begin
          state_next = ST_SELF;
          oe_n_next  = 1'b0;
        end else if (req_valid && req_op != psr_pkg::OP_NONE) begin
          // RULE_01: address held whole select low
          ce_n_next  = 1'b0;
          addr_next  = req_addr;
          dout_next  = req_wdata;
          if (req_op == psr_pkg::OP_WRITE) begin
            // RULE_06: strobe low from select fall
            state_next = ST_WR;
            rw_next    = 1'b0;
            doe_n_next = 1'b0;
          end else begin
            state_next = (req_op == psr_pkg::OP_RMW) ? ST_RMW : ST_RD;
            oe_n_next  = 1'b0;
          end
        end
      end
      ST_RD: begin
        if (at_cnt(cnt_reg, `PSR_RD_LAST)) begin
          rdata_next = sync2_reg;
          rsp_next   = 1'b1;
          ce_n_next  = 1'b1;
          oe_n_next  = 1'b1;
          state_next = ST_PRE;
          cnt_next   = '0;
        end
      end
      ST_WR: begin
        // RULE_02: strobe rises with data held since select fall
        if (at_cnt(cnt_reg, `PSR_CE_CYC - `PSR_CWL_CYC)) begin
          rw_next = 1'b1;
        end
        if (at_cnt(cnt_reg, `PSR_CE_CYC)) begin
          ce_n_next  = 1'b1;
          doe_n_next = 1'b1;
          rsp_next   = 1'b1;
          state_next = ST_PRE;
          cnt_next   = '0;
        end
      end
      ST_RMW: begin
        if (at_cnt(cnt_reg, `PSR_RD_LAST)) begin
          rdata_next = sync2_reg;
          oe_n_next  = 1'b1;
        end
        // RULE_03: drive only after device output released
        if (at_cnt(cnt_reg, `PSR_RD_LAST + `PSR_OHZ_CYC)) begin
          rw_next    = 1'b0;
          doe_n_next = 1'b0;
        end
        if (at_cnt(cnt_reg, `PSR_RD_LAST + `PSR_OHZ_CYC + `PSR_WP_CYC)) begin
          rw_next = 1'b1;
        end
        // RULE_05: full rmw cycle length
        if (at_cnt(cnt_reg, `PSR_RD_LAST + `PSR_OHZ_CYC + `PSR_WP_CYC + `PSR_CWL_CYC)) begin
          ce_n_next  = 1'b1;
          doe_n_next = 1'b1;
          rsp_next   = 1'b1;
          state_next = ST_PRE;
          cnt_next   = '0;
        end
      end
      ST_PRE: begin
        // RULE_04: precharge completes the cycle time
        // RULE_11: also covers refresh delay after select rise
        if (at_cnt(cnt_reg, `PSR_PRE_CYC)) begin
          state_next = ST_IDLE;
          cnt_next   = '0;
        end
      end
      ST_REF_LO: begin
        // RULE_08: short pulse is an auto refresh
        if (at_cnt(cnt_reg, `PSR_FAP_CYC)) begin
          oe_n_next  = 1'b1;
          state_next = ST_REF_HI;
          cnt_next   = '0;
        end
      end
      ST_REF_HI: begin
        // RULE_10: pulse starts spaced by cycle time
        if (at_cnt(cnt_reg, `PSR_FC_CYC - `PSR_FAP_CYC)) begin
          state_next = ST_IDLE;
          cnt_next   = '0;
        end
      end
      ST_SELF: begin
        // RULE_09: long low pulse, select high
        // RULE_15: device paces itself, no pulses sent
        if (cnt_reg >= CNT_W'(`PSR_FAS_CYC - 1)) begin
          cnt_next = cnt_reg;
          if (!sleep_req) begin
            oe_n_next  = 1'b1;
            state_next = ST_SELF_EXIT;
            cnt_next   = '0;
          end
        end
      end
      ST_SELF_EXIT: begin
        // RULE_12: recovery before next select
        if (at_cnt(cnt_reg, `PSR_FRS_CYC)) begin
          state_next = ST_IDLE;
          cnt_next   = '0;
        end
      end
      default: begin
        state_next = ST_INIT;
        cnt_next   = '0;
      end
    endcase
  end

  // refresh timer; a tick beats a same-cycle clear so none is lost
  always_comb begin
    tmr_hit   = tmr_reg == 11'(`PSR_REF_INT - 1);
    tmr_next  = tmr_hit ? 11'h000 : tmr_reg + 11'h001;
    pend_next = tmr_hit | (pend_reg & ~pend_clr);
    // RULE_13: no host refresh duty while self refreshing
    if (state_reg == ST_SELF || state_reg == ST_SELF_EXIT || state_reg == ST_INIT) begin
      tmr_next  = 11'h000;
      pend_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_INIT;
      cnt_reg   <= '0;
      tmr_reg   <= 11'h000;
      pend_reg  <= 1'b0;
      ce_n_reg  <= 1'b1;
      oe_n_reg  <= 1'b1;
      rw_reg    <= 1'b1;
      addr_reg  <= 19'h00000;
      dout_reg  <= 8'h00;
      doe_n_reg <= 1'b1;
      rdata_reg <= 8'h00;
      rsp_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      tmr_reg   <= tmr_next;
      pend_reg  <= pend_next;
      ce_n_reg  <= ce_n_next;
      oe_n_reg  <= oe_n_next;
      rw_reg    <= rw_next;
      addr_reg  <= addr_next;
      dout_reg  <= dout_next;
      doe_n_reg <= doe_n_next;
      rdata_reg <= rdata_next;
      rsp_reg   <= rsp_next;
    end
  end

  assign req_ready = (state_reg == ST_IDLE) && !pend_reg && !sleep_req;
  assign rsp_valid = rsp_reg;
  assign rsp_rdata = rdata_reg;
  assign sleep_active = (state_reg == ST_SELF);
  assign init_done = (state_reg != ST_INIT);
  assign chip_select_n = ce_n_reg;
  assign output_enable_refresh_n = oe_n_reg;
  assign read_write = rw_reg;
  assign addr_lines = addr_reg;
  assign data_lines_o = dout_reg;
  assign data_lines_oe_n = doe_n_reg;

  // helper counters seen only by the checks below
  logic [9:0] lo_cnt, hi_cnt, fall_cnt, rlo_cnt;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_cnt   <= 10'h000;
      hi_cnt   <= 10'h3ff;
      fall_cnt <= 10'h3ff;
      rlo_cnt  <= 10'h000;
    end else begin
      lo_cnt   <= ce_n_reg ? 10'h000 : lo_cnt + 10'(lo_cnt != 10'h3ff);
      hi_cnt   <= !ce_n_reg ? 10'h000 : hi_cnt + 10'(hi_cnt != 10'h3ff);
      fall_cnt <= (ce_n_next == 1'b0 && ce_n_reg) ? 10'h000
                : fall_cnt + 10'(fall_cnt != 10'h3ff);
      rlo_cnt  <= (oe_n_reg || !ce_n_reg) ? 10'h000 : rlo_cnt + 10'(rlo_cnt != 10'h3ff);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_addr_stable: assert property (!ce_n_reg && !$past(ce_n_reg) |-> $stable(addr_reg)) // RULE_01
    else $error("address moved while selected");
  a_wr_setup: assert property ($rose(rw_reg) && !ce_n_reg |->
    !doe_n_reg && !$past(doe_n_reg, 4) && $stable(dout_reg)) // RULE_02
    else $error("write data setup too short");
  a_read_nodrive: assert property (!oe_n_reg && rw_reg && !ce_n_reg |-> doe_n_reg) // RULE_03
    else $error("host drives during read");
  a_cycle_space: assert property ($fell(ce_n_reg) |-> $past(fall_cnt) >= 10'h01c) // RULE_04
    else $error("select cycles too close");
  a_rmw_length: assert property ($rose(ce_n_reg) && $past(state_reg) == ST_RMW |->
    $past(lo_cnt) >= 10'h01a) // RULE_05
    else $error("rmw cycle too short");
  a_wr_strobe: assert property ($fell(ce_n_reg) && !rw_reg |-> (!rw_reg)[*8] ##1 !rw_reg) // RULE_06
    else $error("write strobe released early");
  a_ref_delay: assert property ($fell(oe_n_reg) && ce_n_reg |-> $past(hi_cnt) >= 10'h009) // RULE_11
    else $error("refresh too soon after select");
  a_auto_width: assert property ($rose(oe_n_reg) && $past(state_reg) == ST_REF_LO |->
    $past(rlo_cnt) >= 10'h009 && $past(rlo_cnt) <= 10'h3e6) // RULE_08
    else $error("auto refresh width out of range");
  // early sleep drop may end the pulse at exactly 1000 low cycles
  a_self_width: assert property ($rose(oe_n_reg) && $past(state_reg) == ST_SELF |->
    $past(rlo_cnt) >= 10'h3e7) // RULE_09
    else $error("self refresh too short");
  a_self_exit: assert property ($rose(oe_n_reg) && $past(state_reg) == ST_SELF |->
    (ce_n_reg && oe_n_reg)[*8] ##30 ce_n_reg) // RULE_12
    else $error("select too soon after self refresh");
  a_ref_rate: assert property ($rose(pend_reg) && !sleep_req |->
    ##[1:60] (state_reg == ST_REF_LO || sleep_req)) // RULE_13
    else $error("refresh not issued");
  a_init_hold: assert property (state_reg == ST_INIT && !at_cnt(cnt_reg, INIT_CYC) |=>
    state_reg == ST_INIT && ce_n_reg) // RULE_16
    else $error("init pause cut short");

  c_read: cover property ($rose(ce_n_reg) && $past(state_reg) == ST_RD);
  c_write: cover property ($rose(ce_n_reg) && $past(state_reg) == ST_WR);
  c_rmw: cover property ($rose(ce_n_reg) && $past(state_reg) == ST_RMW);
  c_self: cover property ($rose(oe_n_reg) && $past(state_reg) == ST_SELF);
endmodule // psr_ctrl

// ==== src/psr_pkg.sv ====
// types for the pseudo static ram controller
package psr_pkg;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_RMW, OP_NONE} psr_op_t;
  typedef enum logic [3:0] {
    ST_INIT, ST_IDLE, ST_RD, ST_WR, ST_RMW, ST_PRE,
    ST_REF_LO, ST_REF_HI, ST_SELF, ST_SELF_EXIT
  } psr_state_t;
endpackage

// ==== src/psr_regs.svh ====
// timing constants for the pseudo static ram controller
// Function
// RULE_01: device latches all address bits at chip select fall; host holds them.
// RULE_02: write data is stored at earlier strobe rise; host sets up 30 ns.
// RULE_03: device drives data only in a read; host releases lines then.
// RULE_04: host spaces random read or write cycles at least 230 ns apart.
// RULE_05: host allows at least 290 ns for a read-modify-write cycle.
// RULE_06: host keeps write strobe low 70 ns from chip select fall.
// RULE_07: refresh kind is chosen by pulse width while chip select is high.
// RULE_08: auto refresh pulse lasts 80 ns to 8000 ns.
// RULE_09: refresh low for 8000 ns or more with select high means self refresh.
// RULE_10: host starts auto refresh pulses at least 230 ns apart.
// RULE_11: host waits 80 ns after chip select rise before lowering refresh.
// RULE_12: host delays chip select 300 ns after leaving self refresh.
// RULE_13: host issues 2048 refreshes every 32 ms outside self refresh.
// RULE_14: device counts refresh rows itself for auto and self refresh.
// RULE_15: device paces self refresh with its own timer.
// RULE_16: host holds chip select high 100 us after power-up.
// RULE_17: select cycle with output enable and strobe high only refreshes a row.
`ifndef PSR_REGS_SVH
`define PSR_REGS_SVH
`define PSR_CLK_NS    8
`define PSR_CYC(t)    (((t) + `PSR_CLK_NS - 1) / `PSR_CLK_NS)
`define PSR_T_CE_NS   150
`define PSR_T_RC_NS   230
`define PSR_T_RMW_NS  290
`define PSR_T_P_NS    80
`define PSR_T_CWL_NS  35
`define PSR_T_WP_NS   35
`define PSR_T_OHZ_NS  30
`define PSR_T_WCH_NS  70
`define PSR_T_FAP_NS  80
`define PSR_T_FC_NS   230
`define PSR_T_RFD_NS  80
`define PSR_T_FAS_NS  8000
`define PSR_T_FRS_NS  300
`define PSR_T_INIT_US 100
`define PSR_T_REF_MS  32
`define PSR_REF_ROWS  2048
`define PSR_SYNC_CYC  2
`define PSR_CE_CYC    `PSR_CYC(`PSR_T_CE_NS)
`define PSR_RC_CYC    `PSR_CYC(`PSR_T_RC_NS)
`define PSR_RMW_CYC   `PSR_CYC(`PSR_T_RMW_NS)
`define PSR_PRE_CYC   (`PSR_RC_CYC - `PSR_CE_CYC)
`define PSR_CWL_CYC   `PSR_CYC(`PSR_T_CWL_NS)
`define PSR_WP_CYC    `PSR_CYC(`PSR_T_WP_NS)
`define PSR_OHZ_CYC   `PSR_CYC(`PSR_T_OHZ_NS)
`define PSR_WCH_CYC   `PSR_CYC(`PSR_T_WCH_NS)
`define PSR_FAP_CYC   `PSR_CYC(`PSR_T_FAP_NS)
`define PSR_FC_CYC    `PSR_CYC(`PSR_T_FC_NS)
`define PSR_RFD_CYC   `PSR_CYC(`PSR_T_RFD_NS)
`define PSR_FAS_CYC   `PSR_CYC(`PSR_T_FAS_NS)
`define PSR_FRS_CYC   `PSR_CYC(`PSR_T_FRS_NS)
`define PSR_RD_LAST   (`PSR_CE_CYC + `PSR_SYNC_CYC + 1)
`define PSR_INIT_CYC  `PSR_CYC(`PSR_T_INIT_US * 1000)
`define PSR_REF_INT   ((`PSR_T_REF_MS * 1000000 / `PSR_REF_ROWS) / `PSR_CLK_NS)
`endif
